// ---- rtl/cvi_ctrl_detect.sv ----
// Purpose: Control, format detection and interrupt logic of a clocked
//          video input converter, with a classic Wishbone slave port.
// Assumes: Separate sync video; every video pin, its clock included, is
//          sampled by clk_i, which must run well above the pixel clock.
// Notes:   Field order is fixed at build time by FIELD_ORDER.
//
// What this block does
// - After reset output stays off while detection and interrupts still run.
// - Output starts, status bit 0 sets, at next matching field start.
// - Clearing go stops output at next matching field end, status 0 clears.
// - Interlaced field-one-first starts on field one and alternates.
// - Interlaced field-zero-first starts on field zero and alternates.
// - Interlaced any-field-first starts on either field, passes as arriving.
// - Progressive gives field-zero frames, none under field-one-first.
// - Count total and active samples per line; report after a whole line.
// - Count total and active lines per field; report after a whole field.
// - Decide interlace after one whole field; keep heights per field.
// - The video standard input bus is readable in a standard register.
// - Control packet uses default size and interlace until measured.
// - Each determined aspect loads its register and valid bit; the update interrupt waits for resolution valid.
// - Stable when two of three recent lines match; interrupt on change.
// - Lock low always means unstable video.
// - One interrupt output is the OR of update and stable interrupts.
// - Update interrupt fires whenever detected resolution changes.
// - Control bits two to one enable the two interrupts.
// - Interrupt bits two to one read pending; writing one clears it.
// - Interlaced status bit sets at the start of the second field.
// - Interlaced resolution valid and its interrupt wait for both fields.
`timescale 1ns/1ps
`default_nettype none

module cvi_ctrl_detect
    import cvi_pkg::*;
#(
    parameter cvi_order_e      FIELD_ORDER = CVI_ORDER_ANY_FIRST,
    parameter logic [15:0]     DEF_WIDTH   = `CVI_DEF_WIDTH,
    parameter logic [15:0]     DEF_HEIGHT  = `CVI_DEF_HEIGHT,
    parameter logic            DEF_INTER   = `CVI_DEF_INTERLACE
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [`CVI_AW-1:0]   wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    input  wire logic                 vid_clk_i,
    input  wire logic [`CVI_DW-1:0]   vid_data_i,
    input  wire logic                 vid_datavalid_i,
    input  wire logic                 vid_h_sync_i,
    input  wire logic                 vid_v_sync_i,
    input  wire logic                 vid_f_i,
    input  wire logic                 vid_locked_i,
    input  wire logic [`CVI_STDW-1:0] vid_std_i,
    output cvi_pkg::cvi_beat_s        vout_o,
    output cvi_pkg::cvi_ctrl_s        ctrl_pkt_o,
    output logic                      irq_o
);

    import cvi_pkg::*;

    localparam int CW = `CVI_CW;
    localparam int SW = 6 + `CVI_DW + `CVI_STDW;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation and pixel clock edge detection.

    logic [SW-1:0]        pins_s;
    logic                 s_clk;
    logic                 s_de;
    logic                 s_h;
    logic                 s_v;
    logic                 s_f;
    logic                 s_lock;
    logic [`CVI_DW-1:0]   s_data;
    logic [`CVI_STDW-1:0] s_std;

    cvi_sync #(.W(SW)) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({vid_clk_i, vid_datavalid_i, vid_h_sync_i, vid_v_sync_i,
                 vid_f_i, vid_locked_i, vid_data_i, vid_std_i}),
        .q_o   (pins_s)
    );

    assign {s_clk, s_de, s_h, s_v, s_f, s_lock, s_data, s_std} = pins_s;

    logic clk_d_q;
    logic h_d_q;
    logic v_d_q;
    logic se;
    logic line_end;
    logic field_start;
    logic clr;

    // Losing lock clears all measurements; held sync levels reset high, no false edge.
    assign clr         = rst_i || !s_lock;
    assign se          = s_clk && !clk_d_q && s_lock;
    assign line_end    = se && s_h && !h_d_q;
    assign field_start = se && s_v && !v_d_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_d_q <= 1'b0;
        end else begin
            clk_d_q <= s_clk;
        end
    end

    always_ff @(posedge clk_i) begin
        if (clr) begin
            h_d_q <= 1'b1;
            v_d_q <= 1'b1;
        end else if (se) begin
            h_d_q <= s_h;
            v_d_q <= s_v;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Width measurement.

    logic [CW-1:0] smp_cnt_q;
    logic [CW-1:0] act_cnt_q;
    logic          line_seen_q;
    logic [CW-1:0] tot_smp_q;
    logic [CW-1:0] act_smp_q;
    logic          smp_v_q;
    logic          line_ok;
    logic          wchg;

    assign line_ok = line_end && line_seen_q;
    assign wchg    = line_ok && smp_v_q && (tot_smp_q != smp_cnt_q
                  || (act_cnt_q != '0 && act_smp_q != act_cnt_q));

    always_ff @(posedge clk_i) begin
        if (clr) begin
            smp_cnt_q   <= '0;
            act_cnt_q   <= '0;
            line_seen_q <= 1'b0;
        end else if (line_end) begin
            smp_cnt_q   <= CW'(1);
            act_cnt_q   <= CW'(s_de);
            line_seen_q <= 1'b1;
        end else if (se) begin
            smp_cnt_q <= smp_cnt_q + CW'(1);
            act_cnt_q <= act_cnt_q + CW'(s_de);
        end
    end

    // Lines without active samples keep the last active width.
    always_ff @(posedge clk_i) begin
        if (clr) begin
            tot_smp_q <= '0;
            act_smp_q <= '0;
            smp_v_q   <= 1'b0;
        end else if (line_ok) begin
            tot_smp_q <= smp_cnt_q;
            act_smp_q <= (act_cnt_q != '0) ? act_cnt_q : act_smp_q;
            smp_v_q   <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Height and interlace measurement.

    logic [CW-1:0] ln_cnt_q;
    logic [CW-1:0] act_ln_cnt_q;
    logic          field_seen_q;
    logic          cur_f_q;
    logic [CW-1:0] f0_tot_q;
    logic [CW-1:0] f0_act_q;
    logic [CW-1:0] f1_tot_q;
    logic [CW-1:0] f1_act_q;
    logic          f0_v_q;
    logic          f1_v_q;
    logic          inter_q;
    logic          inter_known_q;
    logic          field_ok;
    logic          hchg;

    assign field_ok = field_start && field_seen_q;
    assign hchg     = field_ok && (cur_f_q
        ? (f1_v_q && (f1_tot_q != ln_cnt_q || f1_act_q != act_ln_cnt_q))
        : (f0_v_q && (f0_tot_q != ln_cnt_q || f0_act_q != act_ln_cnt_q)));

    always_ff @(posedge clk_i) begin
        if (clr) begin
            ln_cnt_q     <= '0;
            act_ln_cnt_q <= '0;
            field_seen_q <= 1'b0;
            cur_f_q      <= 1'b0;
        end else if (field_start) begin
            ln_cnt_q     <= '0;
            act_ln_cnt_q <= '0;
            field_seen_q <= 1'b1;
            cur_f_q      <= s_f;
        end else if (line_ok) begin
            ln_cnt_q     <= ln_cnt_q + CW'(1);
            act_ln_cnt_q <= act_ln_cnt_q + CW'(act_cnt_q != '0);
        end
    end

    // A field is only complete between two field starts.
    always_ff @(posedge clk_i) begin
        if (clr) begin
            f0_tot_q <= '0;
            f0_act_q <= '0;
            f1_tot_q <= '0;
            f1_act_q <= '0;
            f0_v_q   <= 1'b0;
            f1_v_q   <= 1'b0;
        end else if (field_ok && cur_f_q) begin
            f1_tot_q <= ln_cnt_q;
            f1_act_q <= act_ln_cnt_q;
            f1_v_q   <= 1'b1;
        end else if (field_ok) begin
            f0_tot_q <= ln_cnt_q;
            f0_act_q <= act_ln_cnt_q;
            f0_v_q   <= 1'b1;
        end
    end

    // Every field start after the first rechecks the flag, so a new format is seen.
    always_ff @(posedge clk_i) begin
        if (clr) begin
            inter_q       <= 1'b0;
            inter_known_q <= 1'b0;
        end else if (field_ok) begin
            inter_q       <= (s_f != cur_f_q);
            inter_known_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stability, resolution valid and interrupt events.

    logic stab_raw;
    logic stable;
    logic stable_d_q;
    logic res_v;
    logic res_v_q;
    logic chg_q;
    logic upd_ev;
    logic stb_ev;

    cvi_stab #(.CW(CW)) u_stab (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .clr_i    (!s_lock),
        .line_i   (line_ok),
        .total_i  (smp_cnt_q),
        .stable_o (stab_raw)
    );

    assign stable = stab_raw && s_lock;
    assign res_v  = smp_v_q && inter_known_q
                 && (inter_q ? (f0_v_q && f1_v_q) : f0_v_q);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stable_d_q <= 1'b0;
            res_v_q    <= 1'b0;
            chg_q      <= 1'b0;
        end else begin
            stable_d_q <= stable;
            res_v_q    <= res_v;
            chg_q      <= res_v && (wchg || hchg);
        end
    end

    assign stb_ev = stable != stable_d_q;
    assign upd_ev = (res_v && !res_v_q) || chg_q;

    ////////////////////////////////////////////////////////////////////////
    // Output start and stop on field boundaries.

    function automatic logic order_match(input logic f, input logic il,
                                         input logic at_start);
        logic ok;
        ok = 1'b0;
        case (FIELD_ORDER)
            CVI_ORDER_F1_FIRST:  ok = at_start ? f : (il && !f);
            CVI_ORDER_F0_FIRST:  ok = at_start ? !f : (f || !il);
            default:             ok = 1'b1;
        endcase
        return ok;
    endfunction

    cvi_state_e state_q;
    logic       go_q;
    logic       sop_pend_q;
    logic       run;

    assign run = (state_q == CVI_RUN);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= CVI_IDLE;
        end else begin
            case (state_q)
                CVI_IDLE: begin
                    if (go_q) begin
                        state_q <= CVI_ARMED;
                    end
                end
                CVI_ARMED: begin
                    if (!go_q) begin
                        state_q <= CVI_IDLE;
                    end else if (field_start
                                 && order_match(s_f, 1'b1, 1'b1)) begin
                        state_q <= CVI_RUN;
                    end
                end
                CVI_RUN: begin
                    // Lock loss ends the field early; rearms if go is still set, else idles.
                    if (!s_lock) begin
                        state_q <= go_q ? CVI_ARMED : CVI_IDLE;
                    end else if (field_ok && !go_q
                                 && order_match(cur_f_q, inter_q, 1'b0)) begin
                        state_q <= CVI_IDLE;
                    end
                end
                default: begin
                    state_q <= CVI_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sop_pend_q <= 1'b0;
        end else if (field_start) begin
            sop_pend_q <= 1'b1;
        end else if (run && se && s_de) begin
            sop_pend_q <= 1'b0;
        end
    end

    // Fields arrive in source order, so alternation follows the source.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vout_o <= '0;
        end else begin
            vout_o.valid <= run && se && s_de && !s_v;
            vout_o.sop   <= sop_pend_q;
            vout_o.field <= cur_f_q;
            vout_o.data  <= s_data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_pkt_o <= '0;
        end else begin
            ctrl_pkt_o.width      <= smp_v_q ? act_smp_q : DEF_WIDTH;
            ctrl_pkt_o.height     <= f0_v_q ? f0_act_q : DEF_HEIGHT;
            ctrl_pkt_o.interlaced <= inter_known_q ? inter_q : DEF_INTER;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave, control and interrupt registers.

    logic             req;
    logic             wr;
    logic [2:1]       irq_en_q;
    logic [2:1]       irq_q;
    logic [2:1]       irq_clr;
    logic [`CVI_ST_W-1:0] status;

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr  = req && wb_we_i && wb_sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            go_q     <= 1'b0;
            irq_en_q <= 2'h0;
        end else if (wr && wb_adr_i == `CVI_REG_CTRL) begin
            go_q     <= wb_dat_i[`CVI_CTRL_GO];
            irq_en_q <= wb_dat_i[`CVI_CTRL_EN_STB:`CVI_CTRL_EN_UPD];
        end
    end

    assign irq_clr = (wr && wb_adr_i == `CVI_REG_IRQ)
                   ? wb_dat_i[`CVI_IRQ_STB:`CVI_IRQ_UPD] : 2'h0;

    // A new event in the clearing cycle keeps its flag set.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q <= 2'h0;
        end else begin
            irq_q <= (irq_q & ~irq_clr) | {stb_ev, upd_ev};
        end
    end

    assign irq_o = |(irq_q & irq_en_q);

    always_comb begin
        status                     = '0;
        status[`CVI_ST_RUN]        = run;
        status[`CVI_ST_ACT_SMP_V]  = smp_v_q;
        status[`CVI_ST_F0_LN_V]    = f0_v_q;
        status[`CVI_ST_TOT_SMP_V]  = smp_v_q;
        status[`CVI_ST_F1_LN_V]    = f1_v_q;
        status[`CVI_ST_INTERLACED] = inter_q;
        status[`CVI_ST_STABLE]     = stable;
        status[`CVI_ST_RES_V]      = res_v;
    end

    // Unmapped addresses read zero and are still acknowledged.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (req && !wb_we_i) begin
            if (wb_adr_i == `CVI_REG_CTRL) begin
                wb_dat_o <= {29'h0, irq_en_q, go_q};
            end else if (wb_adr_i == `CVI_REG_STATUS) begin
                wb_dat_o <= {21'h0, status};
            end else if (wb_adr_i == `CVI_REG_IRQ) begin
                wb_dat_o <= {29'h0, irq_q, 1'b0};
            end else if (wb_adr_i == `CVI_REG_STD) begin
                wb_dat_o <= {{(32-`CVI_STDW){1'b0}}, s_std};
            end else if (wb_adr_i == `CVI_REG_ACT_SMP) begin
                wb_dat_o <= {16'h0, act_smp_q};
            end else if (wb_adr_i == `CVI_REG_F0_ACT_LN) begin
                wb_dat_o <= {16'h0, f0_act_q};
            end else if (wb_adr_i == `CVI_REG_F1_ACT_LN) begin
                wb_dat_o <= {16'h0, f1_act_q};
            end else if (wb_adr_i == `CVI_REG_TOT_SMP) begin
                wb_dat_o <= {16'h0, tot_smp_q};
            end else if (wb_adr_i == `CVI_REG_F0_TOT_LN) begin
                wb_dat_o <= {16'h0, f0_tot_q};
            end else if (wb_adr_i == `CVI_REG_F1_TOT_LN) begin
                wb_dat_o <= {16'h0, f1_tot_q};
            end else begin
                wb_dat_o <= '0;
            end
        end
    end

endmodule

`default_nettype wire

// ---- rtl/cvi_params.svh ----
// Purpose: Offsets, field positions, reset values and widths for the
//          clocked video input control and format detection block.
// Assumes: Wishbone byte addresses, one 32-bit word per register.
// Notes:   Definitions only.
`ifndef CVI_PARAMS_SVH
`define CVI_PARAMS_SVH

`define CVI_DW            20
`define CVI_CW            16
`define CVI_STDW          3
`define CVI_AW            8

`define CVI_REG_CTRL      8'h00
`define CVI_REG_STATUS    8'h04
`define CVI_REG_IRQ       8'h08
`define CVI_REG_STD       8'h0c
`define CVI_REG_ACT_SMP   8'h10
`define CVI_REG_F0_ACT_LN 8'h14
`define CVI_REG_F1_ACT_LN 8'h18
`define CVI_REG_TOT_SMP   8'h1c
`define CVI_REG_F0_TOT_LN 8'h20
`define CVI_REG_F1_TOT_LN 8'h24

`define CVI_CTRL_GO       0
`define CVI_CTRL_EN_UPD   1
`define CVI_CTRL_EN_STB   2

`define CVI_ST_RUN        0
`define CVI_ST_ACT_SMP_V  3
`define CVI_ST_F0_LN_V    4
`define CVI_ST_TOT_SMP_V  5
`define CVI_ST_F1_LN_V    6
`define CVI_ST_INTERLACED 7
`define CVI_ST_STABLE     8
`define CVI_ST_RES_V      10
`define CVI_ST_W          11

`define CVI_IRQ_UPD       1
`define CVI_IRQ_STB       2

`define CVI_DEF_WIDTH     16'h0780
`define CVI_DEF_HEIGHT    16'h0438
`define CVI_DEF_INTERLACE 1'b0

`endif

// ---- rtl/cvi_pkg.sv ----
// Purpose: Types shared by the clocked video input control block.
// Assumes: cvi_params.svh gives the widths.
// Notes:   Types only; numbers live in the header.
`include "cvi_params.svh"

package cvi_pkg;

    typedef enum logic [1:0] {
        CVI_ORDER_F1_FIRST  = 2'b00,
        CVI_ORDER_F0_FIRST  = 2'b01,
        CVI_ORDER_ANY_FIRST = 2'b10
    } cvi_order_e;

    typedef enum logic [1:0] {
        CVI_IDLE  = 2'b00,
        CVI_ARMED = 2'b01,
        CVI_RUN   = 2'b10
    } cvi_state_e;

    typedef struct packed {
        logic                valid;
        logic                sop;
        logic                field;
        logic [`CVI_DW-1:0]  data;
    } cvi_beat_s;

    typedef struct packed {
        logic [`CVI_CW-1:0]  width;
        logic [`CVI_CW-1:0]  height;
        logic                interlaced;
    } cvi_ctrl_s;

endpackage

// ---- rtl/cvi_sync.sv ----
// Purpose: Two-flop synchroniser for a bus of independent pin levels.
// Assumes: Each bit is a level; no multi-bit coherence is promised.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/1ps
`default_nettype none

module cvi_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;

endmodule

`default_nettype wire

// ---- rtl/cvi_stab.sv ----
// Purpose: Line-length stability detector over the last three lines.
// Assumes: line_i pulses once per completed line with its total count.
// Notes:   clr_i forgets the history, e.g. while lock is lost.
`timescale 1ns/1ps
`default_nettype none

module cvi_stab #(
    parameter int CW = 16
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          clr_i,
    input  wire logic          line_i,
    input  wire logic [CW-1:0] total_i,
    output logic               stable_o
);

    logic [CW-1:0] hist_q [3];
    logic [1:0]    seen_q;

    always_ff @(posedge clk_i) begin
        if (rst_i || clr_i) begin
            seen_q <= 2'h0;
            for (int i = 0; i < 3; i++) begin
                hist_q[i] <= '0;
            end
        end else if (line_i) begin
            hist_q[0] <= total_i;
            hist_q[1] <= hist_q[0];
            hist_q[2] <= hist_q[1];
            if (seen_q != 2'h3) begin
                seen_q <= seen_q + 2'h1;
            end
        end
    end

    // Two equal entries among three recent lines make the input stable.
    always_ff @(posedge clk_i) begin
        if (rst_i || clr_i) begin
            stable_o <= 1'b0;
        end else begin
            stable_o <= (seen_q >= 2'h2 && hist_q[0] == hist_q[1])
                     || (seen_q == 2'h3 && (hist_q[0] == hist_q[2]
                                         || hist_q[1] == hist_q[2]));
        end
    end

endmodule

`default_nettype wire

// ---- sim/cvi_ctrl_detect_asserts.sv ----
// Purpose: Port-level checks of the video input control block.
// Assumes: One clock domain with a synchronous reset.
// Notes:   Bound to every instance of the block.
`timescale 1ns/1ps
`default_nettype none
module cvi_ctrl_detect_chk
    import cvi_pkg::*;
#(
    parameter logic [15:0] DEF_WIDTH  = 16'h0000,
    parameter logic [15:0] DEF_HEIGHT = 16'h0000,
    parameter logic        DEF_INTER  = 1'b0
) (
    input wire logic               clk_i,
    input wire logic               rst_i,
    input wire logic               wb_cyc_i,
    input wire logic               wb_stb_i,
    input wire logic               wb_we_i,
    input wire logic [7:0]         wb_adr_i,
    input wire logic [3:0]         wb_sel_i,
    input wire logic [31:0]        wb_dat_i,
    input wire logic               wb_ack_o,
    input wire logic               vid_locked_i,
    input wire cvi_pkg::cvi_beat_s vout_o,
    input wire cvi_pkg::cvi_ctrl_s ctrl_pkt_o,
    input wire logic               irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic req;
    logic wr;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr  = req && wb_we_i && wb_sel_i[0];
    ////////////////////////////////////////
    AST_RESET_QUIET: assert property ($fell(rst_i) |->
        !vout_o.valid && !irq_o && !wb_ack_o) else $error("busy at reset");
    AST_PKT_DEFAULT: assert property ($fell(rst_i) |=>
        ctrl_pkt_o == {DEF_WIDTH, DEF_HEIGHT, DEF_INTER})
        else $error("control packet not default");
    AST_IRQ_GATED: assert property (wr && wb_adr_i == 8'h00 &&
        wb_dat_i[2:1] == 2'b00 |=> !irq_o) else $error("irq not gated");
    AST_IRQ_LEVEL: assert property (irq_o && !wr |=> irq_o)
        else $error("irq dropped without a write");
    AST_LOCK_QUIET: assert property (!vid_locked_i [*8] |->
        !vout_o.valid) else $error("output while unlocked");
    AST_ACK_ONE: assert property (req |=> wb_ack_o)
        else $error("ack late");
    AST_ACK_DROP: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held");
    AST_BEAT_PULSE: assert property (vout_o.valid |=> !vout_o.valid)
        else $error("beat held");
    cover property (vout_o.valid);
    cover property ($rose(irq_o));
    cover property (wr && wb_adr_i == 8'h08);
endmodule
bind cvi_ctrl_detect cvi_ctrl_detect_chk #(.DEF_WIDTH(DEF_WIDTH),
    .DEF_HEIGHT(DEF_HEIGHT), .DEF_INTER(DEF_INTER)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .vid_locked_i(vid_locked_i),
    .vout_o(vout_o), .ctrl_pkt_o(ctrl_pkt_o), .irq_o(irq_o));
`default_nettype wire

// ---- sim/cvi_vid_src.sv ----
// Purpose: Separate-sync video source facing the block.
// Assumes: Pixel clock of 160 ns that runs free.
// Notes:   Pins change on the falling pixel edge, well clear of sampling.
`timescale 1ns/1ps
`default_nettype none
module cvi_vid_src #(
    parameter int TOT = 8,
    parameter int ACT = 6,
    parameter int LN  = 6
) (
    input  wire logic   inter_i,
    output logic        clk_o,
    output logic [19:0] dat_o,
    output logic        dv_o,
    output logic        hs_o,
    output logic        vs_o,
    output logic        f_o
);
    int x = 0;
    int y = 0;
    initial clk_o = 1'b0;
    initial f_o = 1'b0;
    always #80 clk_o = ~clk_o;
    // Data keeps changing in blanking so stale samples cannot match.
    always @(negedge clk_o) begin
        x = (x + 1) % TOT;
        if (x == 0) y = (y + 1) % LN;
        if (x == 0 && y == 0) f_o <= inter_i & ~f_o;
    end
    assign dv_o  = (y != 0) && (x < ACT);
    assign hs_o  = (x == TOT - 1);
    assign vs_o  = (y == 0);
    assign dat_o = 20'(x * 64 + y);
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// Purpose: Register-level test of the video input control block.
// Assumes: Default field order and packet size.
// Notes:   Waits are bounded; a timeout ends the run as a failure.
`timescale 1ns/1ps
`default_nettype none
`include "cvi_params.svh"
module tb_top;
    import cvi_pkg::*;
    localparam int TOT = 8;
    localparam int ACT = 6;
    localparam int LN  = 6;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_we = 1'b0;
    logic [7:0]  wb_adr = 8'h00;
    logic [31:0] wb_dw = 32'h0, wb_dr, rv;
    logic        wb_ack, vclk, dv, hs, vs, fld, irq;
    logic        lock = 1'b0;
    logic        inter = 1'b0;
    logic [2:0]  std = 3'h5;
    logic [19:0] vdat;
    cvi_beat_s   vout;
    cvi_ctrl_s   pkt;
    int          errors = 0, compares = 0, nb = 0, nf = 0;
    always #5 clk_i = ~clk_i;
    cvi_ctrl_detect u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dw),
        .wb_dat_o(wb_dr), .wb_ack_o(wb_ack), .vid_clk_i(vclk),
        .vid_data_i(vdat), .vid_datavalid_i(dv), .vid_h_sync_i(hs),
        .vid_v_sync_i(vs), .vid_f_i(fld), .vid_locked_i(lock),
        .vid_std_i(std), .vout_o(vout), .ctrl_pkt_o(pkt), .irq_o(irq));
    cvi_vid_src #(.TOT(TOT), .ACT(ACT), .LN(LN)) u_src (
        .inter_i(inter), .clk_o(vclk), .dat_o(vdat), .dv_o(dv), .hs_o(hs),
        .vs_o(vs), .f_o(fld));
    ////////////////////////////////////////
    task automatic wrap_up;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input string nm, input logic [32:0] seen,
                         input logic [32:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Read data lands in rv at the ack edge.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= w;
        wb_adr <= a;
        wb_dw  <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            wrap_up();
        end
        rv = wb_dr;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic poll(input int b, input logic v);
        int n;
        n = 0;
        do begin
            bus(1'b0, `CVI_REG_STATUS, 32'h0);
            n++;
        end while (rv[b] !== v && n < 1500);
        check("status bit", rv[b], v);
        if (rv[b] !== v) wrap_up();
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        bus(1'b0, `CVI_REG_CTRL, 32'h0);
        check("ctrl", rv, 32'h0);
        check("packet", pkt, {16'h0780, 16'h0438, 1'b0});
        lock <= 1'b1;
        poll(`CVI_ST_RES_V, 1'b1);
        bus(1'b0, `CVI_REG_STD, 32'h0);
        check("standard", rv, 32'h5);
        bus(1'b0, `CVI_REG_ACT_SMP, 32'h0);
        check("active samples", rv, ACT);
        bus(1'b0, `CVI_REG_TOT_SMP, 32'h0);
        check("total samples", rv, TOT);
        bus(1'b0, `CVI_REG_F0_TOT_LN, 32'h0);
        check("total lines", rv, LN);
        bus(1'b0, `CVI_REG_F0_ACT_LN, 32'h0);
        check("active lines", rv, LN - 1);
        poll(`CVI_ST_STABLE, 1'b1);
        check("irq masked", irq, 1'b0);
        bus(1'b0, `CVI_REG_IRQ, 32'h0);
        check("flags", rv[2:1], 2'b11);
        bus(1'b1, `CVI_REG_CTRL, 32'h6);
        check("irq on", irq, 1'b1);
        bus(1'b1, `CVI_REG_IRQ, 32'h2);
        bus(1'b0, `CVI_REG_IRQ, 32'h0);
        check("one flag cleared", rv[2:1], 2'b10);
        check("irq held", irq, 1'b1);
        bus(1'b1, `CVI_REG_IRQ, 32'h4);
        check("irq off", irq, 1'b0);
        bus(1'b1, `CVI_REG_CTRL, 32'h1);
        poll(`CVI_ST_RUN, 1'b1);
        repeat (1600) @(posedge clk_i) begin
            nb += int'(vout.valid === 1'b1);
            nf += int'(vout.valid === 1'b1 && vout.field !== 1'b0);
        end
        check("beats seen", nb > 0, 1'b1);
        check("field one beats", nf, 0);
        bus(1'b1, `CVI_REG_CTRL, 32'h0);
        poll(`CVI_ST_RUN, 1'b0);
        inter <= 1'b1;
        poll(`CVI_ST_INTERLACED, 1'b1);
        lock <= 1'b0;
        poll(`CVI_ST_STABLE, 1'b0);
        wrap_up();
    end
endmodule
`default_nettype wire
